/* rtl/prs_consts.svh */
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH
`define PRS_PW           32
`define PRS_PORT0        1'h0
`define PRS_P0_BOOT_SEL0 0
`define PRS_P0_BOOT_SEL1 11
`define PRS_P0_SM_SEL2   10
`define PRS_P0_SM_SEL1   12
`define PRS_P0_RET_CLK   13
`define PRS_P0_SM_SEL0   4
`define PRS_P0_SM_CLK    5
`define PRS_P0_SM_DIN    6
`define PRS_P0_SM_DOUT   7
`define PRS_P1_T_DIN     16
`define PRS_P1_T_DOUT    17
`define PRS_P1_T_CLK     18
`define PRS_P1_T_MODE    19
`define PRS_P1_ORD_PIN   1
`define PRS_BOOT_WAIT    3'h4
`define PRS_BOOT_CNT_ONE 3'h1
`define PRS_BOOT_SERMEM  2'h2
`define PRS_P0_OEN_RST   32'hFFFF_DFFF
`define PRS_P1_OEN_RST   32'hFFFF_FFFF
`endif

/* rtl/prs_pkg.sv */
package prs_pkg;
`include "prs_consts.svh"
  typedef logic [`PRS_PW-1:0] prs_word_t;

  typedef struct packed {
    prs_word_t dir;
    prs_word_t od;
    prs_word_t pull_en;
    prs_word_t pull_up;
    prs_word_t dout;
    prs_word_t alt;
  } prs_port_cfg_t;

  typedef struct packed {
    prs_word_t out;
    prs_word_t oe_n;
    prs_word_t pu;
    prs_word_t pd;
  } prs_pad_t;

  typedef enum logic [2:0] {
    PRS_BOOT_WAIT_S  = 3'b001,
    PRS_BOOT_LATCH_S = 3'b010,
    PRS_BOOT_DONE_S  = 3'b100
  } prs_boot_st_t;

  typedef struct packed {
    prs_port_cfg_t [1:0] cfg;
    logic [1:0]          tck_s;
    logic [2:0]          b0_s;
    logic [2:0]          b1_s;
    logic [1:0]          boot_flt;
    logic [2:0]          wait_cnt;
    prs_boot_st_t        boot_st;
    logic [1:0]          boot_sel;
    logic                mem_ovr;
    prs_pad_t [1:0]      pad;
  } prs_state_t;
endpackage : prs_pkg

/* rtl/prs_port_reset_logic.sv */
// Function
// - Ordinary pins come up as floating inputs, no pull-up or pull-down.
// - Port 1 bits 19..16 and port 0 bit 13 default to test-access functions.
// - Test-access input pins float after reset and accept sequences at once.
// - Test data out floats when idle, push-pull only while shifting.
// - Returned clock is push-pull, low in reset, test clock after three stages.
// - Port configuration never selects test pins; their reset values match others, except the returned clock, which drives low.
// - Boot pins port 0 bits 11 and 0 sampled after reset, before first fetch.
// - Serial-memory boot only: port 0 bits 7,5,4,6 reset into memory function.
// - Extra memory selects on port 0 bits 12,10 keep ordinary reset state.
// - Each input can float, use weak pull-up, or weak pull-down.
// - Each output can be open-drain or push-pull.
`timescale 1ns/1ns
`default_nettype none
`include "prs_consts.svh"

module prs_port_reset_logic (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire prs_pkg::prs_word_t   p0_pin_in,
  input  wire prs_pkg::prs_word_t   p1_pin_in,
  input  wire prs_pkg::prs_word_t   p0_alt_out,
  input  wire prs_pkg::prs_word_t   p1_alt_out,
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_port,
  input  wire prs_pkg::prs_port_cfg_t cfg_data,
  input  wire logic                 test_data_out,
  input  wire logic                 test_data_out_en,
  input  wire logic                 serial_mem_data_out,
  input  wire logic                 serial_mem_clock,
  input  wire logic                 serial_mem_select_0,
  output prs_pkg::prs_pad_t         pad_p0,
  output prs_pkg::prs_pad_t         pad_p1,
  output logic                      returned_test_clock_pin,
  output logic [1:0]                boot_sel,
  output logic                      boot_from_serial_mem,
  output logic                      fetch_enable
);
  import prs_pkg::*;

  // ==========================================================================
  // Reset image
  // ==========================================================================
  // Every pad floats in reset except the returned clock, which drives low.
  localparam prs_pad_t PAD0_RST = '{out: '0, oe_n: `PRS_P0_OEN_RST, pu: '0, pd: '0};
  localparam prs_pad_t PAD1_RST = '{out: '0, oe_n: `PRS_P1_OEN_RST, pu: '0, pd: '0};
  localparam prs_state_t ST_RST = '{
    cfg: '0, tck_s: '0, b0_s: '0, b1_s: '0, boot_flt: '0, wait_cnt: '0,
    boot_st: PRS_BOOT_WAIT_S, boot_sel: '0, mem_ovr: 1'b0,
    pad: {PAD1_RST, PAD0_RST}
  };

  prs_state_t st_r;
  prs_state_t st_nxt;

  // ==========================================================================
  // Pad helpers
  // ==========================================================================
  // Returns {out, oe_n, pu, pd} for an ordinary pin from its configuration.
  function automatic logic [3:0] prs_gpio_pad(input prs_port_cfg_t c,
                                              input prs_word_t a,
                                              input int i);
    logic v;
    logic drv;
    v   = c.alt[i] ? a[i] : c.dout[i];
    drv = c.dir[i] && !(c.od[i] && v);
    prs_gpio_pad = {v && !c.od[i], !drv,
                    !c.dir[i] && c.pull_en[i] && c.pull_up[i],
                    !c.dir[i] && c.pull_en[i] && !c.pull_up[i]};
  endfunction : prs_gpio_pad

  // Fixed function pad with no pulls: value and whether it drives.
  function automatic logic [3:0] prs_fix_pad(input logic v, input logic drv);
    prs_fix_pad = {v, !drv, 1'b0, 1'b0};
  endfunction : prs_fix_pad

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_nxt = st_r;

    // The pipe feeds the pad flop, which is the third stage of the clock.
    st_nxt.tck_s = {st_r.tck_s[0], p1_pin_in[`PRS_P1_T_CLK]};
    st_nxt.b0_s  = {st_r.b0_s[1:0], p0_pin_in[`PRS_P0_BOOT_SEL0]};
    st_nxt.b1_s  = {st_r.b1_s[1:0], p0_pin_in[`PRS_P0_BOOT_SEL1]};
    if (st_r.b0_s[1] == st_r.b0_s[2]) begin
      st_nxt.boot_flt[0] = st_r.b0_s[2];
    end
    if (st_r.b1_s[1] == st_r.b1_s[2]) begin
      st_nxt.boot_flt[1] = st_r.b1_s[2];
    end

    if (cfg_wr) begin
      st_nxt.cfg[cfg_port] = cfg_data;
      // Software taking over port 0 ends the boot-time memory pin override.
      if (cfg_port == `PRS_PORT0) begin
        st_nxt.mem_ovr = 1'b0;
      end
    end

    // Latching comes after the clear so a boot decision is never lost.
    case (st_r.boot_st)
      PRS_BOOT_WAIT_S: begin
        if (st_r.wait_cnt == `PRS_BOOT_WAIT) begin
          st_nxt.boot_st = PRS_BOOT_LATCH_S;
        end else begin
          st_nxt.wait_cnt = st_r.wait_cnt + `PRS_BOOT_CNT_ONE;
        end
      end
      PRS_BOOT_LATCH_S: begin
        st_nxt.boot_sel = st_r.boot_flt;
        st_nxt.mem_ovr  = (st_r.boot_flt == `PRS_BOOT_SERMEM);
        st_nxt.boot_st  = PRS_BOOT_DONE_S;
      end
      PRS_BOOT_DONE_S: begin
        st_nxt.boot_st = PRS_BOOT_DONE_S;
      end
      default: begin
        st_nxt.boot_st = PRS_BOOT_WAIT_S;
      end
    endcase

    // Ordinary pins, memory selects 1 and 2 included, follow configuration only.
    for (int i = 0; i < `PRS_PW; i++) begin
      {st_nxt.pad[0].out[i], st_nxt.pad[0].oe_n[i], st_nxt.pad[0].pu[i],
       st_nxt.pad[0].pd[i]} = prs_gpio_pad(st_r.cfg[0], p0_alt_out, i);
      {st_nxt.pad[1].out[i], st_nxt.pad[1].oe_n[i], st_nxt.pad[1].pu[i],
       st_nxt.pad[1].pd[i]} = prs_gpio_pad(st_r.cfg[1], p1_alt_out, i);
    end

    // Test-access pins override configuration unconditionally.
    {st_nxt.pad[1].out[`PRS_P1_T_DIN], st_nxt.pad[1].oe_n[`PRS_P1_T_DIN],
     st_nxt.pad[1].pu[`PRS_P1_T_DIN], st_nxt.pad[1].pd[`PRS_P1_T_DIN]}
      = prs_fix_pad(1'b0, 1'b0);
    {st_nxt.pad[1].out[`PRS_P1_T_MODE], st_nxt.pad[1].oe_n[`PRS_P1_T_MODE],
     st_nxt.pad[1].pu[`PRS_P1_T_MODE], st_nxt.pad[1].pd[`PRS_P1_T_MODE]}
      = prs_fix_pad(1'b0, 1'b0);
    {st_nxt.pad[1].out[`PRS_P1_T_CLK], st_nxt.pad[1].oe_n[`PRS_P1_T_CLK],
     st_nxt.pad[1].pu[`PRS_P1_T_CLK], st_nxt.pad[1].pd[`PRS_P1_T_CLK]}
      = prs_fix_pad(1'b0, 1'b0);
    {st_nxt.pad[1].out[`PRS_P1_T_DOUT], st_nxt.pad[1].oe_n[`PRS_P1_T_DOUT],
     st_nxt.pad[1].pu[`PRS_P1_T_DOUT], st_nxt.pad[1].pd[`PRS_P1_T_DOUT]}
      = prs_fix_pad(test_data_out, test_data_out_en);
    {st_nxt.pad[0].out[`PRS_P0_RET_CLK], st_nxt.pad[0].oe_n[`PRS_P0_RET_CLK],
     st_nxt.pad[0].pu[`PRS_P0_RET_CLK], st_nxt.pad[0].pd[`PRS_P0_RET_CLK]}
      = prs_fix_pad(st_r.tck_s[1], 1'b1);

    if (st_r.mem_ovr) begin
      {st_nxt.pad[0].out[`PRS_P0_SM_DOUT], st_nxt.pad[0].oe_n[`PRS_P0_SM_DOUT],
       st_nxt.pad[0].pu[`PRS_P0_SM_DOUT], st_nxt.pad[0].pd[`PRS_P0_SM_DOUT]}
        = prs_fix_pad(serial_mem_data_out, 1'b1);
      {st_nxt.pad[0].out[`PRS_P0_SM_CLK], st_nxt.pad[0].oe_n[`PRS_P0_SM_CLK],
       st_nxt.pad[0].pu[`PRS_P0_SM_CLK], st_nxt.pad[0].pd[`PRS_P0_SM_CLK]}
        = prs_fix_pad(serial_mem_clock, 1'b1);
      {st_nxt.pad[0].out[`PRS_P0_SM_SEL0], st_nxt.pad[0].oe_n[`PRS_P0_SM_SEL0],
       st_nxt.pad[0].pu[`PRS_P0_SM_SEL0], st_nxt.pad[0].pd[`PRS_P0_SM_SEL0]}
        = prs_fix_pad(serial_mem_select_0, 1'b1);
      {st_nxt.pad[0].out[`PRS_P0_SM_DIN], st_nxt.pad[0].oe_n[`PRS_P0_SM_DIN],
       st_nxt.pad[0].pu[`PRS_P0_SM_DIN], st_nxt.pad[0].pd[`PRS_P0_SM_DIN]}
        = prs_fix_pad(1'b0, 1'b0);
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pad_p0                  = st_r.pad[0];
  assign pad_p1                  = st_r.pad[1];
  assign returned_test_clock_pin = st_r.pad[0].out[`PRS_P0_RET_CLK];
  assign boot_sel                = st_r.boot_sel;
  assign fetch_enable            = (st_r.boot_st == PRS_BOOT_DONE_S);
  assign boot_from_serial_mem    = fetch_enable && (st_r.boot_sel == `PRS_BOOT_SERMEM);

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_ord_float;
    (!st_r.cfg[1].dir[`PRS_P1_ORD_PIN] && !st_r.cfg[1].pull_en[`PRS_P1_ORD_PIN])
      |=> pad_p1.oe_n[`PRS_P1_ORD_PIN] && !pad_p1.pu[`PRS_P1_ORD_PIN]
          && !pad_p1.pd[`PRS_P1_ORD_PIN];
  endproperty
  a_ord_float: assert property (p_ord_float)
    else $error("ordinary pin not floating");

  property p_tap_float;
    pad_p1.oe_n[`PRS_P1_T_DIN] && pad_p1.oe_n[`PRS_P1_T_MODE] && pad_p1.oe_n[`PRS_P1_T_CLK]
      && !(|pad_p1.pu[`PRS_P1_T_MODE:`PRS_P1_T_DIN])
      && !(|pad_p1.pd[`PRS_P1_T_MODE:`PRS_P1_T_DIN]);
  endproperty
  a_tap_float: assert property (p_tap_float)
    else $error("test input pin not floating");

  property p_tdo;
    test_data_out_en
      |=> !pad_p1.oe_n[`PRS_P1_T_DOUT] && pad_p1.out[`PRS_P1_T_DOUT] == $past(test_data_out);
  endproperty
  a_tdo: assert property (p_tdo) else $error("test data out not driven");

  property p_tdo_idle;
    !test_data_out_en [*2] |-> pad_p1.oe_n[`PRS_P1_T_DOUT];
  endproperty
  a_tdo_idle: assert property (p_tdo_idle)
    else $error("test data out driven when idle");

  property p_ret_clk;
    fetch_enable |-> !pad_p0.oe_n[`PRS_P0_RET_CLK]
      && returned_test_clock_pin == $past(p1_pin_in[`PRS_P1_T_CLK], 3);
  endproperty
  a_ret_clk: assert property (p_ret_clk) else $error("returned clock wrong");

  property p_boot_src;
    $rose(fetch_enable) |-> boot_sel == $past(st_r.boot_flt, 1);
  endproperty
  a_boot_src: assert property (p_boot_src) else $error("boot select not sampled");

  property p_boot_hold;
    fetch_enable ##1 fetch_enable |-> $stable(boot_sel);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot select changed");

  property p_mem_pins;
    st_r.mem_ovr |=> !pad_p0.oe_n[`PRS_P0_SM_DOUT] && !pad_p0.oe_n[`PRS_P0_SM_SEL0]
      && pad_p0.out[`PRS_P0_SM_CLK] == $past(serial_mem_clock);
  endproperty
  a_mem_pins: assert property (p_mem_pins)
    else $error("memory pins not in boot function");

  property p_mem_sel1;
    (st_r.mem_ovr && !st_r.cfg[0].dir[`PRS_P0_SM_SEL1]) |=> pad_p0.oe_n[`PRS_P0_SM_SEL1];
  endproperty
  a_mem_sel1: assert property (p_mem_sel1)
    else $error("memory select 1 overridden");

  property p_pull_up;
    (!st_r.cfg[1].dir[`PRS_P1_ORD_PIN] && st_r.cfg[1].pull_en[`PRS_P1_ORD_PIN]
      && st_r.cfg[1].pull_up[`PRS_P1_ORD_PIN]) |=> pad_p1.pu[`PRS_P1_ORD_PIN];
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("pull-up not applied");

  property p_open_drain;
    (st_r.cfg[1].dir[`PRS_P1_ORD_PIN] && st_r.cfg[1].od[`PRS_P1_ORD_PIN]
      && !st_r.cfg[1].alt[`PRS_P1_ORD_PIN] && st_r.cfg[1].dout[`PRS_P1_ORD_PIN])
      |=> pad_p1.oe_n[`PRS_P1_ORD_PIN];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

endmodule : prs_port_reset_logic
`default_nettype wire

/* tb/prs_far_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// External pins: boot straps and the debug probe clock.
module prs_far_model (
  input  wire logic         clk_sys,
  input  wire logic [1:0]   boot_code,
  input  wire logic         tck_run,
  output prs_pkg::prs_word_t p0_pin_in,
  output prs_pkg::prs_word_t p1_pin_in
);
  import prs_pkg::*;
  logic [1:0] div_r = 2'h0;
  logic       tck_r = 1'b0;
  // The probe clock is slow against the bus clock, so each level outlives the synchronizer.
  always @(posedge clk_sys) begin
    div_r <= div_r + 2'h1;
    if (!tck_run) begin
      tck_r <= 1'b0;
    end else if (div_r == 2'h3) begin
      tck_r <= ~tck_r;
    end
  end
  always_comb begin
    p0_pin_in     = 32'h0000_0000;
    p0_pin_in[0]  = boot_code[0];
    p0_pin_in[11] = boot_code[1];
    p1_pin_in     = 32'h0000_0000;
    p1_pin_in[18] = tck_r;
  end
endmodule : prs_far_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import prs_pkg::*;
  logic          clk_sys = 1'b0;
  logic          sys_rst = 1'b1;
  prs_word_t     p0_pin_in;
  prs_word_t     p1_pin_in;
  prs_word_t     p0_alt_out = 32'h0000_0000;
  prs_word_t     p1_alt_out = 32'h0000_0000;
  logic          cfg_wr = 1'b0;
  logic          cfg_port = 1'b0;
  prs_port_cfg_t cfg_data = {6{32'h0000_0000}};
  logic          tdo = 1'b0;
  logic          tdo_en = 1'b0;
  logic          smd = 1'b0;
  logic          smc = 1'b0;
  logic          sms = 1'b0;
  logic [1:0]    boot_code = 2'h0;
  logic          tck_run = 1'b0;
  logic [2:0]    hist = 3'h0;
  prs_pad_t      pad_p0;
  prs_pad_t      pad_p1;
  logic          ret_clk;
  logic [1:0]    boot_sel;
  logic          boot_mem;
  logic          fetch_en;
  int            n_errors = 0;
  int            checks_done = 0;

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    hist <= {hist[1:0], p1_pin_in[18]};
  end

  prs_far_model far (.clk_sys(clk_sys), .boot_code(boot_code), .tck_run(tck_run),
    .p0_pin_in(p0_pin_in), .p1_pin_in(p1_pin_in));
  prs_port_reset_logic DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .p0_pin_in(p0_pin_in),
    .p1_pin_in(p1_pin_in), .p0_alt_out(p0_alt_out), .p1_alt_out(p1_alt_out),
    .cfg_wr(cfg_wr), .cfg_port(cfg_port), .cfg_data(cfg_data), .test_data_out(tdo),
    .test_data_out_en(tdo_en), .serial_mem_data_out(smd), .serial_mem_clock(smc),
    .serial_mem_select_0(sms), .pad_p0(pad_p0), .pad_p1(pad_p1),
    .returned_test_clock_pin(ret_clk), .boot_sel(boot_sel), .boot_from_serial_mem(boot_mem),
    .fetch_enable(fetch_en));

  // ==========================================================
  // Comparison and closing.
  task automatic chk_word(input prs_word_t got, input prs_word_t exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : chk_bit
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // Scenarios.
  task automatic t_reset_boot(input logic [1:0] code);
    sys_rst <= 1'b1;
    boot_code <= code;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_word(pad_p0.oe_n, 32'hFFFF_DFFF, "p0 oe_n in reset");
    chk_word(pad_p0.pu | pad_p0.pd | pad_p1.pu | pad_p1.pd, 32'h0, "pulls");
    chk_bit(ret_clk, 1'b0, "returned clock in reset");
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bit(fetch_en, 1'b0, "fetch early");
    @(negedge clk_sys);
    chk_bit(fetch_en, 1'b1, "fetch late");
    chk_word({30'h0, boot_sel}, {30'h0, code}, "boot sel");
    chk_bit(boot_mem, code == 2'h2, "memory boot");
    chk_word(pad_p1.oe_n, 32'hFFFF_FFFF, "p1 oe_n");
  endtask : t_reset_boot
  task automatic t_tdo;
    @(posedge clk_sys);
    tdo_en <= 1'b1;
    tdo <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bit(pad_p1.oe_n[17], 1'b0, "tdo drive");
    chk_bit(pad_p1.out[17], 1'b1, "tdo value");
    @(posedge clk_sys);
    tdo_en <= 1'b0;
    tdo <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bit(pad_p1.oe_n[17], 1'b1, "tdo idle");
  endtask : t_tdo
  task automatic t_returned_test_clock_pin;
    @(posedge clk_sys);
    tck_run <= 1'b1;
    repeat (24) begin
      @(negedge clk_sys);
      chk_bit(ret_clk, hist[2], "returned clock");
    end
    @(posedge clk_sys);
    tck_run <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask : t_returned_test_clock_pin
  task automatic t_mem_boot;
    @(posedge clk_sys);
    smd <= 1'b1;
    smc <= 1'b1;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_word(pad_p0.oe_n, 32'hFFFF_DF4F, "memory oe_n");
    chk_word(pad_p0.out, 32'h0000_00A0, "memory out");
    @(posedge clk_sys);
    boot_code <= 2'h1;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_word({30'h0, boot_sel}, 32'h0000_0002, "boot held");
  endtask : t_mem_boot
  task automatic t_cfg;
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_data <= '{32'h0000_000F, 32'h0000_000A, 32'h0000_0300, 32'h0000_0100,
                  32'h0000_0009, 32'h0000_0000};
    p1_alt_out <= 32'hFFFF_FFFF;
    @(posedge clk_sys);
    cfg_port <= 1'b1;
    cfg_data <= '{32'hFFF0_FFFF, 32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0000_0002};
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_word(pad_p0.out, 32'h0000_0001, "p0 out");
    chk_word(pad_p0.oe_n, 32'hFFFF_DFF8, "p0 oe_n");
    chk_word(pad_p0.pu, 32'h0000_0100, "p0 pu");
    chk_word(pad_p0.pd, 32'h0000_0200, "p0 pd");
    chk_word(pad_p1.oe_n, 32'h000F_0000, "p1 oe_n");
    chk_word(pad_p1.pd, 32'h0000_0000, "p1 pd");
    chk_word(pad_p1.out & 32'hFFF0_FFFF, 32'h0000_0002, "p1 alt out");
  endtask : t_cfg
  // Port 1 pin 1 as a pulled-up input, then as an open-drain output left high.
  task automatic t_pin_modes;
    @(posedge clk_sys);
    cfg_wr   <= 1'b1;
    cfg_data <= '{32'h0000_0000, 32'h0000_0002, 32'h0000_0002, 32'h0000_0002,
                  32'h0000_0002, 32'h0000_0000};
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_word(pad_p1.pu, 32'h0000_0002, "p1 pull-up");
    chk_word(pad_p1.oe_n, 32'hFFFF_FFFF, "p1 inputs");
    @(posedge clk_sys);
    cfg_wr       <= 1'b1;
    cfg_data.dir <= 32'h0000_0002;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_word(pad_p1.oe_n, 32'hFFFF_FFFF, "open drain high");
    chk_word(pad_p1.out, 32'h0000_0000, "open drain out");
  endtask : t_pin_modes

  initial begin
    t_reset_boot(2'h0);
    t_tdo();
    t_returned_test_clock_pin();
    t_reset_boot(2'h2);
    t_mem_boot();
    t_cfg();
    t_pin_modes();
    close_out();
  end
  // The scenarios take about 91 cycles; 1000 leaves ample room.
  initial begin
    #(1000 * 100);
    n_errors++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
